// file: dv/lsm_fabric_model.sv
// User fabric model driving the slice group inputs
module lsm_fabric_model (
    // Clock
    input wire logic                    pclk,
    // Fabric toward the slice group
    output lsm_pkg::lsm_slice_in_s [3:0] slice_in,
    output logic [3:0]                  cnt_clr,
    output logic                        carry_chain_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet fabric from time zero
    initial begin
        slice_in = '0;
        cnt_clr = 4'h0;
        carry_chain_in = 1'b0;
    end
    // One cycle of values just after an edge; never loads ROM
    task automatic step(input lsm_pkg::lsm_slice_in_s [3:0] v,
                        input logic [3:0] clr, input logic cin);
        @(posedge pclk);
        slice_in <= v;
        cnt_clr <= clr;
        carry_chain_in <= cin;
    endtask
endmodule

// file: dv/lsm_slice_group_assertions.sv
// Port-level checker for the slice group, bound to the top module
module lsm_sg_checker (
    // Clock and reset
    input wire logic                          pclk,
    input wire logic                          presetn,
    // APB port
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [11:0]                   paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    // Fabric side
    input wire lsm_pkg::lsm_slice_in_s [3:0]  slice_in,
    input wire logic [3:0]                    cnt_clr,
    input wire logic                          carry_chain_in,
    input wire lsm_pkg::lsm_slice_out_s [3:0] slice_out,
    input wire logic [1:0]                    count [4],
    input wire logic                          carry_chain_out
);
    logic [1:0]            mode_q;
    logic [2:0]            fn0_q;
    lsm_pkg::lsm_slice_in_s s0;
    logic                  acc;
    logic                  mapped;
    logic                  rip;
    logic                  cnt0;
    // Decode of the access and of the mapped window
    assign s0 = slice_in[0];
    assign acc = psel && penable && pready && pwrite;
    assign rip = mode_q == lsm_pkg::LSM_MODE_RIPPLE;
    assign cnt0 = rip && fn0_q == lsm_pkg::LSM_FN_COUNT && !cnt_clr[0];
    assign mapped = paddr inside {lsm_pkg::OFS_CTRL, lsm_pkg::OFS_FUNC,
        lsm_pkg::OFS_STATUS} || (paddr >= lsm_pkg::OFS_LUT0 &&
        paddr <= lsm_pkg::OFS_LUT7 && paddr[1:0] == 2'h0);
    // Shadow of group mode and slice 0 function
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= lsm_pkg::RST_MODE;
            fn0_q  <= lsm_pkg::RST_FUNC;
        end else if (acc && paddr == lsm_pkg::OFS_CTRL) begin
            mode_q <= pwdata[1:0];
        end else if (acc && paddr == lsm_pkg::OFS_FUNC) begin
            fn0_q <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (
        psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready longer than one cycle");
    a_unmapped_err: assert property (
        psel && !penable && !mapped |=> pslverr)
        else $error("no error on unmapped access");
    a_clear_async: assert property (
        cnt_clr[0] |-> count[0] == 2'h0) else $error("clear not immediate");
    a_count_hold: assert property (
        !s0.cnt_en && !s0.cnt_load |=> cnt_clr[0] || $stable(count[0]))
        else $error("idle counter moved");
    a_count_load: assert property (
        cnt0 && s0.cnt_load |=> cnt_clr[0] || count[0] == $past(s0.op_b))
        else $error("preset not loaded");
    a_count_step: assert property (
        cnt0 && s0.cnt_en && !s0.cnt_load |=> cnt_clr[0] || count[0] ==
        $past(count[0]) + ($past(s0.add_nsub) ? 2'h1 : 2'h3))
        else $error("counter step wrong");
    a_add_sum: assert property (
        rip && fn0_q == lsm_pkg::LSM_FN_ADD |=> slice_out[0].arith ==
        $past(s0.op_a) + $past(s0.op_b) + $past(carry_chain_in))
        else $error("sum wrong");
    a_ge_cmp: assert property (
        rip && fn0_q == lsm_pkg::LSM_FN_GE |=> slice_out[0].cmp ==
        ($past(s0.op_a) >= $past(s0.op_b))) else $error("compare wrong");
    a_carry_pass: assert property (
        !rip |=> carry_chain_out == $past(carry_chain_in))
        else $error("carry not passed");
    // Main scenarios reached
    c_count: cover property (cnt0 && s0.cnt_en);
    c_error: cover property (pslverr);
    c_ram_wr: cover property (mode_q == 2'h3 && slice_in[1].op_a[0]);
endmodule

bind lsm_slice_group lsm_sg_checker i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .slice_in(slice_in), .cnt_clr(cnt_clr),
    .carry_chain_in(carry_chain_in), .slice_out(slice_out), .count(count),
    .carry_chain_out(carry_chain_out));

// file: dv/tb_top.sv
// Self-checking bench for the slice group
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] P0 = 16'hA5C3;
    localparam logic [15:0] P1 = 16'h0F0F;
    logic                         pclk, presetn, psel, penable, pwrite;
    logic [11:0]                  paddr;
    logic [31:0]                  pwdata, prdata, rd;
    logic                         pready, pslverr, err, cco, cci, c;
    logic [3:0]                   cnt_clr, ram_rdata;
    logic [1:0]                   pdp_rdata, a, b, e;
    logic [1:0]                   count [4];
    lsm_pkg::lsm_slice_in_s [3:0]  slice_in, v;
    lsm_pkg::lsm_slice_out_s [3:0] slice_out;
    int                           miscompares, tests_run, cycles, k;

    lsm_slice_group i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slice_in(slice_in), .cnt_clr(cnt_clr), .carry_chain_in(cci),
        .slice_out(slice_out), .count(count), .carry_chain_out(cco),
        .ram_rdata(ram_rdata), .pdp_rdata(pdp_rdata));
    lsm_fabric_model i_fab (.pclk(pclk), .slice_in(slice_in),
        .cnt_clr(cnt_clr), .carry_chain_in(cci));

    // Clock and hang guard
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until ready is seen
    task automatic apb(input logic wr, input logic [11:0] ad,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Launch fabric values; results show one call later
    task automatic fab(input logic [3:0] clr, input logic cin);
        i_fab.step(v, clr, cin);
        @(negedge pclk);
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        v = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped access, read-only status
        apb(0, lsm_pkg::OFS_CTRL, 0);
        check(rd, 0);
        apb(0, lsm_pkg::OFS_LUT7, 0);
        check(rd, 0);
        apb(0, 12'h00C, 0);
        check(err, 1);
        check(rd, 0);
        apb(1, lsm_pkg::OFS_STATUS, 32'hFFFFFFFF);
        apb(0, lsm_pkg::OFS_STATUS, 0);
        check(rd, 0);
        // Logic mode: two tables and the five-input select
        apb(1, lsm_pkg::OFS_LUT0, {16'h0, P0});
        apb(1, lsm_pkg::OFS_LUT0 + 12'h004, {16'h0, P1});
        for (int i = 0; i < 16; i++) begin
            v[0].lut0_in = i[3:0];
            v[0].lut1_in = ~i[3:0];
            v[0].sel5 = i[0];
            repeat (2) fab(4'h0, 1'b0);
            check(slice_out[0].lut_f, {P1[15-i], P0[i]});
            check(slice_out[0].lut5, i[0] ? P1[15-i] : P0[i]);
        end
        // Ripple mode: every arithmetic and compare function except count
        apb(1, lsm_pkg::OFS_CTRL, 32'h1);
        for (int f = 0; f < 8; f++) begin
            if (f == 3) continue;
            apb(1, lsm_pkg::OFS_FUNC, 32'h1111 * f);
            for (int n = 0; n < 32; n++) begin
                a = n[1:0];
                b = n[3:2];
                c = n[4];
                v[0].op_a = a;
                v[0].op_b = b;
                v[0].add_nsub = n[0];
                v[0].sel5 = n[1];
                repeat (2) fab(4'h0, c);
                case (f)
                    0: e = a + b + c;
                    1: e = a + ~b + c;
                    2: e = n[0] ? a + b + c : a + ~b + c;
                    4: e = {1'b0, a >= b};
                    5: e = {1'b0, a != b};
                    6: e = {1'b0, a <= b};
                    default: e = a + (b & {2{n[1]}}) + c;
                endcase
                if (f inside {4, 5, 6}) check(slice_out[0].cmp, e);
                else check(slice_out[0].arith, e);
            end
        end
        // Carry ripples through all four slices
        apb(1, lsm_pkg::OFS_FUNC, 0);
        v = '0;
        for (int s = 0; s < 4; s++) v[s].op_a = 2'h3;
        repeat (2) fab(4'h0, 1'b1);
        check({cco, slice_out[3].arith}, 3'h4);
        repeat (2) fab(4'h0, 1'b0);
        check({cco, slice_out[3].arith}, 3'h3);
        // Counter: preset, wrap up, wrap down, asynchronous clear
        apb(1, lsm_pkg::OFS_FUNC, 32'h3333);
        v = '0;
        v[0].cnt_load = 1'b1;
        v[0].op_b = 2'h2;
        fab(4'h0, 1'b0);
        v[0].cnt_load = 1'b0;
        v[0].cnt_en = 1'b1;
        v[0].add_nsub = 1'b1;
        repeat (3) fab(4'h0, 1'b0);
        check(count[0], 0);
        v[0].add_nsub = 1'b0;
        repeat (3) fab(4'h0, 1'b0);
        check(count[0], 3);
        v[0].cnt_en = 1'b0;
        fab(4'h1, 1'b0);
        check(count[0], 0);
        // RAM mode: fill all sixteen words, then read back
        apb(1, lsm_pkg::OFS_CTRL, 32'h3);
        v = '0;
        v[1].op_a[0] = 1'b1;
        for (int n = 0; n < 16; n++) begin
            v[1].lut0_in = n[3:0];
            {v[2].op_b, v[0].op_b} = n[3:0] ^ 4'h9;
            fab(4'h0, 1'b0);
        end
        v = '0;
        for (int n = 0; n < 16; n++) begin
            v[1].lut0_in = n[3:0];
            repeat (2) fab(4'h0, 1'b0);
            check(ram_rdata, n[3:0] ^ 4'h9);
        end
        // Pseudo dual port: write by slice 1, read on companion address
        apb(1, lsm_pkg::OFS_CTRL, 32'h13);
        v[1].op_a[0] = 1'b1;
        v[1].lut0_in = 4'h5;
        v[0].op_b = 2'h1;
        fab(4'h0, 1'b0);
        v = '0;
        v[2].lut0_in = 4'h5;
        repeat (2) fab(4'h0, 1'b0);
        check(pdp_rdata, 1);
        // ROM mode: preload over APB, fabric writes have no effect
        apb(1, lsm_pkg::OFS_CTRL, 32'h2);
        for (k = 0; k < 8; k++) apb(1, lsm_pkg::OFS_LUT0 + 12'(4 * k), 1 << k);
        v[1].op_a[0] = 1'b1;
        v[0].op_b = 2'h3;
        v[2].op_b = 2'h3;
        for (int i = 0; i < 8; i++) begin
            for (int s = 0; s < 4; s++) v[s].lut0_in = i[3:0];
            repeat (2) fab(4'h0, 1'b0);
            for (int s = 0; s < 4; s++)
                check(slice_out[s].lut_f, {i == 2*s+1, i == 2*s});
        end
        apb(0, lsm_pkg::OFS_LUT0, 0);
        check(rd, 1);
        report_and_stop();
    end
endmodule

// file: hw/lsm_pkg.sv
// Shared constants, types and layouts for the logic slice group
package lsm_pkg;

    // Slice group geometry
    localparam int NUM_SLICES = 4;
    localparam int NUM_LUTS   = 8;
    localparam int LUT_BITS   = 16;

    // APB register byte offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_FUNC   = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_LUT0   = 12'h020;
    localparam logic [11:0] OFS_LUT7   = 12'h03C;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PDP_BIT  = 4;

    // Function register: three bits per slice
    localparam int FUNC_STRIDE = 4;

    // Status register fields
    localparam int STAT_CNT_LSB   = 0;
    localparam int STAT_CARRY_BIT = 8;

    // Reset values
    localparam logic [1:0]  RST_MODE = 2'h0;
    localparam logic [2:0]  RST_FUNC = 3'h0;
    localparam logic [15:0] RST_LUT  = 16'h0000;

    // Slice group operating mode, gray coded
    typedef enum logic [1:0] {
        LSM_MODE_LOGIC  = 2'b00,
        LSM_MODE_RIPPLE = 2'b01,
        LSM_MODE_RAM    = 2'b11,
        LSM_MODE_ROM    = 2'b10
    } lsm_mode_e;

    // Ripple mode function of one slice
    typedef enum logic [2:0] {
        LSM_FN_ADD    = 3'h0,
        LSM_FN_SUB    = 3'h1,
        LSM_FN_ADDSUB = 3'h2,
        LSM_FN_COUNT  = 3'h3,
        LSM_FN_GE     = 3'h4,
        LSM_FN_NE     = 3'h5,
        LSM_FN_LE     = 3'h6,
        LSM_FN_MULT   = 3'h7
    } lsm_func_e;

    // Fabric inputs of one slice
    typedef struct packed {
        logic [3:0] lut0_in;   // LUT0 inputs, RAM address on slice 1
        logic [3:0] lut1_in;   // LUT1 inputs
        logic       sel5;      // Fifth input, multiplier bit in ripple
        logic [1:0] op_a;      // Operand A, op_a[0] is RAM write enable
        logic [1:0] op_b;      // Operand B, preset value, RAM data
        logic       add_nsub;  // Add high, subtract low; count up high
        logic       cnt_en;    // Counter enable
        logic       cnt_load;  // Synchronous preset load
    } lsm_slice_in_s;

    // Registered fabric outputs of one slice
    typedef struct packed {
        logic [1:0] lut_f;     // LUT1 and LUT0 outputs
        logic       lut5;      // Five-input function
        logic [1:0] arith;     // Sum or difference
        logic       cmp;       // Comparator result
    } lsm_slice_out_s;

endpackage

// file: hw/lsm_slice_group.sv
// Four-slice programmable function unit with APB configuration port
//
// Operation
// - Group runs exactly one of four modes
// - Each LUT gives any four-input function
// - Fifth input selects between LUTs
// - Two-bit add, subtract, dynamic add/subtract
// - Two-bit up/down counter, async clear
// - Counter loads preset on clock edge
// - Compare A,B: ge, ne, le
// - Partial-product add step for multipliers
// - Carry in and carry out chain slices
// - Slices 0 and 2 form 16x4 RAM
// - Slice 1 supplies RAM address, control
// - Pseudo dual port: write slice, read companion
// - ROM mode reads all four slices

module lsm_slice_group (
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB configuration port
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Fabric side inputs
    input  wire lsm_pkg::lsm_slice_in_s [3:0] slice_in,
    // Counter clears, asynchronous
    input  wire logic [3:0]               cnt_clr,
    input  wire logic                     carry_chain_in,
    // Fabric side outputs
    output lsm_pkg::lsm_slice_out_s [3:0] slice_out,
    output logic      [1:0]               count [4],
    output logic                          carry_chain_out,
    // Memory read ports
    output logic      [3:0]               ram_rdata,
    output logic      [1:0]               pdp_rdata
);

    // Configuration state
    lsm_pkg::lsm_mode_e        mode_q;
    logic                      pdp_q;
    lsm_pkg::lsm_func_e [3:0]  func_q;
    logic [15:0]               lut_q [8];

    // APB handshake state
    logic                      pready_q;
    logic                      pslverr_q;
    logic [31:0]               prdata_q;

    // Combinational results
    lsm_pkg::lsm_slice_out_s [3:0] out_d;
    logic                      cout_d;
    logic [3:0]                ram_rdata_d;
    logic [1:0]                pdp_rdata_d;
    logic [3:0]                cnt_carry;
    // RAM control from slice 1, PDP read address from slice 2
    logic                      ram_we;
    logic [3:0]                ram_addr;
    logic [3:0]                pdp_raddr;
    // Completed write strobe
    logic                      apb_wr;

    // Bit of a LUT selected by its four inputs
    function automatic logic lut_bit(input logic [15:0] word,
                                     input logic [3:0]  sel);
        lut_bit = word[sel];
    endfunction

    // Register offset is one of the eight LUT words
    function automatic logic is_lut(input logic [11:0] addr);
        is_lut = (addr >= lsm_pkg::OFS_LUT0) &&
                 (addr <= lsm_pkg::OFS_LUT7) && (addr[1:0] == 2'h0);
    endfunction

    // Word is decoded by the bus
    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == lsm_pkg::OFS_CTRL) ||
                    (addr == lsm_pkg::OFS_FUNC) ||
                    (addr == lsm_pkg::OFS_STATUS) || is_lut(addr);
    endfunction

    // Index of a LUT word from its offset
    function automatic logic [2:0] lut_idx(input logic [11:0] addr);
        logic [11:0] rel;
        rel = addr - lsm_pkg::OFS_LUT0;
        lut_idx = rel[4:2];
    endfunction

    // Read data of a mapped register
    function automatic logic [31:0] read_word(input logic [11:0] addr);
        logic [31:0] w;
        // Reserved bits read as zero
        w = 32'h0000_0000;
        if (addr == lsm_pkg::OFS_CTRL) begin
            w[lsm_pkg::CTRL_MODE_LSB +: 2] = mode_q;
            w[lsm_pkg::CTRL_PDP_BIT]       = pdp_q;
        end else if (addr == lsm_pkg::OFS_FUNC) begin
            for (int s = 0; s < lsm_pkg::NUM_SLICES; s++) begin
                w[s*lsm_pkg::FUNC_STRIDE +: 3] = func_q[s];
            end
        end else if (addr == lsm_pkg::OFS_STATUS) begin
            for (int s = 0; s < lsm_pkg::NUM_SLICES; s++) begin
                w[lsm_pkg::STAT_CNT_LSB + 2*s +: 2] = count[s];
            end
            w[lsm_pkg::STAT_CARRY_BIT] = carry_chain_out;
        end else if (is_lut(addr)) begin
            w[15:0] = lut_q[lut_idx(addr)];
        end
        read_word = w;
    endfunction

    // Write takes effect at the completing access edge
    assign apb_wr = psel & penable & pready_q & pwrite;

    // APB answer: no wait states, data registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            // Ready and error answer each setup a cycle later
            pready_q  <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~is_mapped(paddr);
            // Read data captured in setup, held to next setup
            if (psel && !penable) begin
                prdata_q <= (pwrite || !is_mapped(paddr)) ?
                            32'h0000_0000 : read_word(paddr);
            end
        end
    end

    // Mode and function configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= lsm_pkg::lsm_mode_e'(lsm_pkg::RST_MODE);
            pdp_q  <= 1'b0;
            for (int s = 0; s < lsm_pkg::NUM_SLICES; s++) begin
                func_q[s] <= lsm_pkg::lsm_func_e'(lsm_pkg::RST_FUNC);
            end
        end else if (apb_wr) begin
            if (paddr == lsm_pkg::OFS_CTRL) begin
                // A single field holds the mode: one mode at a time
                mode_q <= lsm_pkg::lsm_mode_e'(
                          pwdata[lsm_pkg::CTRL_MODE_LSB +: 2]);
                // PDP pairing select
                pdp_q  <= pwdata[lsm_pkg::CTRL_PDP_BIT];
            end else if (paddr == lsm_pkg::OFS_FUNC) begin
                // One function field per slice
                for (int s = 0; s < lsm_pkg::NUM_SLICES; s++) begin
                    func_q[s] <= lsm_pkg::lsm_func_e'(
                                 pwdata[s*lsm_pkg::FUNC_STRIDE +: 3]);
                end
            end
        end
    end

    // RAM control comes from slice 1, PDP read address from slice 2
    assign ram_we    = slice_in[1].op_a[0];
    assign ram_addr  = slice_in[1].lut0_in;
    assign pdp_raddr = slice_in[2].lut0_in;

    // LUT storage: configuration writes and RAM writes
    for (genvar k = 0; k < lsm_pkg::NUM_LUTS; k++) begin : g_lut
        // Owning slice and which of its two LUTs
        localparam int SLICE = k / 2;
        localparam int HALF  = k % 2;
        // Slices 0 and 2 hold data; companion slice 2 idle in PDP
        localparam logic IN_SPR = (SLICE == 0) || (SLICE == 2);
        localparam logic IN_PDP = (SLICE == 0);
        // RAM write strobe of this word
        logic ram_wr;

        // No user writes outside RAM mode, so ROM stays as loaded
        assign ram_wr = (mode_q == lsm_pkg::LSM_MODE_RAM) && ram_we &&
                        (pdp_q ? IN_PDP : IN_SPR);

        // Configuration port wins over a same-cycle RAM write
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lut_q[k] <= lsm_pkg::RST_LUT;
            end else if (apb_wr && is_lut(paddr) &&
                         lut_idx(paddr) == 3'(k)) begin
                lut_q[k] <= pwdata[15:0];
            end else if (ram_wr) begin
                lut_q[k][ram_addr] <= slice_in[SLICE].op_b[HALF];
            end
        end
    end

    // Counters with async clear and sync preset
    for (genvar s = 0; s < lsm_pkg::NUM_SLICES; s++) begin : g_cnt
        // Count only as a ripple counter
        logic run;
        logic [1:0] cnt_q;
        assign run = (mode_q == lsm_pkg::LSM_MODE_RIPPLE) &&
                     (func_q[s] == lsm_pkg::LSM_FN_COUNT);

        // Clear needs no clock edge
        always_ff @(posedge pclk or negedge presetn
                    or posedge cnt_clr[s]) begin
            if (!presetn) begin
                cnt_q <= 2'h0;
            end else if (cnt_clr[s]) begin
                cnt_q <= 2'h0;
            end else if (run && slice_in[s].cnt_load) begin
                cnt_q <= slice_in[s].op_b;
            end else if (run && slice_in[s].cnt_en) begin
                cnt_q <= slice_in[s].add_nsub ? cnt_q + 2'h1
                                              : cnt_q - 2'h1;
            end
        end

        // Terminal count feeds the carry chain
        assign cnt_carry[s] = slice_in[s].cnt_en & ~slice_in[s].cnt_load &
                              (slice_in[s].add_nsub ? (cnt_q == 2'h3)
                                                    : (cnt_q == 2'h0));

        // Counter flop drives the port
        assign count[s] = cnt_q;
    end

    // Per-slice LUT, arithmetic and compare paths, carry rippled
    always_comb begin
        logic       c;
        logic [1:0] a;
        logic [1:0] b;
        logic [1:0] bx;
        logic [2:0] sum;
        logic [3:0] sel1;
        // Carry enters at slice 0
        c   = carry_chain_in;
        a   = 2'h0;
        b   = 2'h0;
        bx  = 2'h0;
        sum = 3'h0;
        sel1 = 4'h0;
        out_d = '0;
        for (int s = 0; s < lsm_pkg::NUM_SLICES; s++) begin
            a = slice_in[s].op_a;
            b = slice_in[s].op_b;
            // ROM shares LUT0 inputs across both LUTs of a slice
            sel1 = (mode_q == lsm_pkg::LSM_MODE_ROM) ?
                   slice_in[s].lut0_in : slice_in[s].lut1_in;
            out_d[s].lut_f[0] = lut_bit(lut_q[2*s],
                                        slice_in[s].lut0_in);
            out_d[s].lut_f[1] = lut_bit(lut_q[2*s+1], sel1);
            out_d[s].lut5 = slice_in[s].sel5 ? out_d[s].lut_f[1]
                                             : out_d[s].lut_f[0];

            // Operand B as the adder sees it
            case (func_q[s])
                lsm_pkg::LSM_FN_SUB:    bx = ~b;
                lsm_pkg::LSM_FN_ADDSUB: bx = slice_in[s].add_nsub
                                             ? b : ~b;
                // Multiplier bit gates B
                lsm_pkg::LSM_FN_MULT:   bx = b &
                                             {2{slice_in[s].sel5}};
                default:                bx = b;
            endcase
            sum = {1'b0, a} + {1'b0, bx} + {2'h0, c};

            // Comparator of A and B
            case (func_q[s])
                lsm_pkg::LSM_FN_GE: out_d[s].cmp = (a >= b);
                lsm_pkg::LSM_FN_NE: out_d[s].cmp = (a != b);
                lsm_pkg::LSM_FN_LE: out_d[s].cmp = (a <= b);
                default:            out_d[s].cmp = 1'b0;
            endcase

            // Sum and carry are only driven in ripple mode
            if (mode_q == lsm_pkg::LSM_MODE_RIPPLE) begin
                case (func_q[s])
                    lsm_pkg::LSM_FN_ADD, lsm_pkg::LSM_FN_SUB,
                    lsm_pkg::LSM_FN_ADDSUB, lsm_pkg::LSM_FN_MULT: begin
                        out_d[s].arith = sum[1:0];
                        c = sum[2];
                    end
                    lsm_pkg::LSM_FN_COUNT: begin
                        c = cnt_carry[s];
                    end
                    default: begin
                        // Compare functions pass the carry on
                        c = c;
                    end
                endcase
            end
        end
        // Carry out of slice 3
        cout_d = c;
    end

    // RAM read paths, addressed without a clock
    always_comb begin
        ram_rdata_d = {lut_bit(lut_q[5], ram_addr),
                       lut_bit(lut_q[4], ram_addr),
                       lut_bit(lut_q[1], ram_addr),
                       lut_bit(lut_q[0], ram_addr)};
        // Read-only port of the pseudo dual port pair
        pdp_rdata_d = {lut_bit(lut_q[1], pdp_raddr),
                       lut_bit(lut_q[0], pdp_raddr)};

        // Ports read zero outside their mode
        if (mode_q != lsm_pkg::LSM_MODE_RAM) begin
            ram_rdata_d = 4'h0;
            pdp_rdata_d = 2'h0;
        end else if (pdp_q) begin
            ram_rdata_d[3:2] = 2'h0;
        end else begin
            pdp_rdata_d = 2'h0;
        end
    end

    // Output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slice_out       <= '0;
            carry_chain_out <= 1'b0;
            ram_rdata       <= 4'h0;
            pdp_rdata       <= 2'h0;
        end else begin
            slice_out       <= out_d;
            carry_chain_out <= cout_d;
            ram_rdata       <= ram_rdata_d;
            pdp_rdata       <= pdp_rdata_d;
        end
    end

    // Bus outputs straight from their flops
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

endmodule
